// *** crs_core_model.sv ***
// file: behavioural core model driving datapath, alu, pc and interrupt strobes
`timescale 1ns/1ps

module crs_core_model (
   input wire logic ref_clk,
   input wire logic [31:0] dp_rd_data,
   input wire logic irq_accept,
   output logic dp_wr_en,
   output crs_pkg::crs_sel_t dp_wr_sel,
   output crs_pkg::crs_size_t dp_wr_size,
   output logic [31:0] dp_wr_data,
   output crs_pkg::crs_sel_t dp_rd_sel,
   output crs_pkg::crs_size_t dp_rd_size,
   output logic alu_flag_we,
   output logic alu_wide,
   output logic [31:0] alu_result,
   output logic alu_carry,
   output logic alu_overflow,
   output logic pc_we,
   output logic [crs_pkg::CRS_AW-1:0] pc_next,
   output logic irq_req,
   output logic irq_nmi,
   output logic [2:0] irq_level,
   output logic swi_exec,
   output logic [5:0] swi_num
);
   import crs_pkg::*;

   // everything idle at time zero
   initial begin
      {dp_wr_en, alu_flag_we, alu_wide, alu_carry, alu_overflow, pc_we} = '0;
      {irq_req, irq_nmi, swi_exec} = '0;
      {dp_wr_data, alu_result, pc_next, irq_level, swi_num} = '0;
      dp_wr_sel = CRS_SEL_D0;
      dp_rd_sel = CRS_SEL_D0;
      dp_wr_size = CRS_SZ_WORD;
      dp_rd_size = CRS_SZ_WORD;
   end

   // one-cycle register write; data inverted once released
   task dp_write(input crs_sel_t s, input crs_size_t z, input logic [31:0] d);
      @(posedge ref_clk);
      dp_wr_en <= 1'b1;
      dp_wr_sel <= s;
      dp_wr_size <= z;
      dp_wr_data <= d;
      @(posedge ref_clk);
      dp_wr_en <= 1'b0;
      dp_wr_data <= ~d;
   endtask : dp_write

   // select, let the read register load, take its value
   task dp_read(input crs_sel_t s, input crs_size_t z, output logic [31:0] d);
      @(posedge ref_clk);
      dp_rd_sel <= s;
      dp_rd_size <= z;
      repeat (2) @(posedge ref_clk);
      d = dp_rd_data;
   endtask : dp_read

   // one alu flag update
   task alu(input logic w, input logic [31:0] r, input logic c, input logic o);
      @(posedge ref_clk);
      {alu_flag_we, alu_wide, alu_result, alu_carry, alu_overflow} <= {1'b1, w, r, c, o};
      @(posedge ref_clk);
      alu_flag_we <= 1'b0;
      alu_result <= ~r;
   endtask : alu

   // program counter load
   task pc_load(input logic [CRS_AW-1:0] p);
      @(posedge ref_clk);
      pc_we <= 1'b1;
      pc_next <= p;
      @(posedge ref_clk);
      pc_we <= 1'b0;
      pc_next <= ~p;
   endtask : pc_load

   // software interrupt instruction
   task swi(input logic [5:0] n);
      @(posedge ref_clk);
      swi_exec <= 1'b1;
      swi_num <= n;
      @(posedge ref_clk);
      swi_exec <= 1'b0;
   endtask : swi

   // request held one cycle, acknowledge taken at the closing edge
   task irq(input logic nmi, input logic [2:0] l, output logic acc);
      @(posedge ref_clk);
      irq_req <= 1'b1;
      irq_nmi <= nmi;
      irq_level <= l;
      @(posedge ref_clk);
      acc = irq_accept;
      irq_req <= 1'b0;
      irq_nmi <= 1'b0;
   endtask : irq
endmodule : crs_core_model

// *** crs_cpu_register_set.sv ***
// module: cpu register set with apb access and datapath ports
//
// Notes on behaviour
// RL1 - four 16-bit data registers; first two also split into byte halves
// RL2 - third pairs with first, fourth with second, later one is upper half
// RL3 - two 16-bit address registers, pairable to 32 bits, second is upper
// RL4 - 16-bit frame base register for frame-relative addressing
// RL5 - 20-bit vector table base register
// RL6 - 20-bit program counter holds next instruction address
// RL7 - separate user and interrupt stack pointers, chosen by stack-select flag
// RL8 - 16-bit static base register
// RL9 - flag word is 11 bits wide
// RL10 - carry flag captures carry, borrow or shifted-out bit from the alu
// RL11 - software keeps the debug flag at zero
// RL12 - zero flag set when result is zero, cleared otherwise
// RL13 - sign flag set when result is negative, cleared otherwise
// RL14 - bank flag selects physical register bank 0 or 1
// RL15 - overflow flag set on overflow, cleared otherwise
// RL16 - interrupt enable flag gates maskable interrupts
// RL17 - any interrupt acknowledge clears the interrupt enable flag
// RL18 - stack flag zero picks interrupt stack, one picks user stack
// RL19 - hardware interrupt or software interrupt 0..31 clears stack flag
// RL20 - priority level is 3 bits, levels 0 to 7
// RL21 - interrupt accepted only above the current priority level; code accepts a non-maskable request at any level
// RL22 - reserved flag bit written as zero, reads undefined
// RL23 - all registers reset to zero
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps

module crs_cpu_register_set #(
   parameter int APB_AW = 8
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dp_wr_en,
   input wire crs_pkg::crs_sel_t dp_wr_sel,
   input wire crs_pkg::crs_size_t dp_wr_size,
   input wire logic [31:0] dp_wr_data,
   input wire crs_pkg::crs_sel_t dp_rd_sel,
   input wire crs_pkg::crs_size_t dp_rd_size,
   output logic [31:0] dp_rd_data,
   input wire logic alu_flag_we,
   input wire logic alu_wide,
   input wire logic [31:0] alu_result,
   input wire logic alu_carry,
   input wire logic alu_overflow,
   input wire logic pc_we,
   input wire logic [crs_pkg::CRS_AW-1:0] pc_next,
   input wire logic irq_req,
   input wire logic irq_nmi,
   input wire logic [2:0] irq_level,
   output logic irq_accept,
   input wire logic swi_exec,
   input wire logic [5:0] swi_num,
   output logic [crs_pkg::CRS_AW-1:0] pc_value,
   output logic [crs_pkg::CRS_AW-1:0] vector_base,
   output logic [crs_pkg::CRS_DW-1:0] stack_pointer,
   output logic [crs_pkg::CRS_DW-1:0] frame_base_value,
   output logic [crs_pkg::CRS_DW-1:0] static_base_value,
   output logic [crs_pkg::CRS_FW-1:0] flags_value
);
   import crs_pkg::*;

   crs_state_t s_reg;
   crs_state_t s_next;
   logic bank;
   logic apb_setup;
   logic apb_wr;
   logic apb_hit;
   crs_sel_t apb_sel;
   logic [2:0] cur_ipl;
   logic alu_zero;

   // true for selectors that own a paired upper register
   function automatic logic pairable(crs_sel_t sel);
      return (sel == CRS_SEL_D0) || (sel == CRS_SEL_D1) || (sel == CRS_SEL_A0);
   endfunction : pairable

   // bank index of the upper half of a pair
   function automatic logic [2:0] pair_hi(crs_sel_t sel);
      logic [2:0] lo;
      lo = sel[2:0];
      if (sel == CRS_SEL_A0) begin
         return 3'(CRS_SEL_A1);
      end
      return 3'(lo + 3'h2);
   endfunction : pair_hi

   // byte lane merge for 16-bit targets
   function automatic logic [15:0] merge16(logic [15:0] old, crs_size_t sz, logic [31:0] d);
      logic [15:0] w;
      w = d[15:0];
      if (sz == CRS_SZ_LOW) begin
         w = {old[15:8], d[7:0]}; // RL1
      end else if (sz == CRS_SZ_HIGH) begin
         w = {d[7:0], old[7:0]}; // RL1
      end
      return w;
   endfunction : merge16

   // write one register of the given bank
   function automatic crs_state_t put(crs_state_t st, logic bk, crs_sel_t sel,
                                      crs_size_t sz, logic [31:0] d);
      logic [2:0] lo;
      lo = sel[2:0];
      case (sel)
         CRS_SEL_D0, CRS_SEL_D1, CRS_SEL_D2, CRS_SEL_D3,
         CRS_SEL_A0, CRS_SEL_A1, CRS_SEL_FB: begin
            st.bank[bk][lo] = merge16(st.bank[bk][lo], sz, d); // RL1 RL3 RL4 RL14
            if (sz == CRS_SZ_PAIR && pairable(sel)) begin
               st.bank[bk][pair_hi(sel)] = d[31:16]; // RL2 RL3
            end
         end
         CRS_SEL_SB: st.sb = merge16(st.sb, sz, d); // RL8
         CRS_SEL_VTB: st.vtb = d[CRS_AW-1:0]; // RL5
         CRS_SEL_PC: st.pc = d[CRS_AW-1:0]; // RL6
         CRS_SEL_USP: st.user_stack_pointer = merge16(st.user_stack_pointer, sz, d); // RL7
         CRS_SEL_ISP: st.interrupt_stack_pointer = merge16(st.interrupt_stack_pointer, sz, d); // RL7
         CRS_SEL_FLG: st.flags_word = d[CRS_FW-1:0]; // RL9 RL22
         default: st = st;
      endcase
      return st;
   endfunction : put

   // read one register of the given bank, sized
   function automatic logic [31:0] get(crs_state_t st, logic bk, crs_sel_t sel,
                                       crs_size_t sz);
      logic [2:0] lo;
      logic [15:0] w;
      logic [15:0] up;
      logic [31:0] r;
      logic narrow;
      lo = sel[2:0];
      w = '0;
      up = '0;
      r = '0;
      narrow = 1'b1;
      case (sel)
         CRS_SEL_D0, CRS_SEL_D1, CRS_SEL_D2, CRS_SEL_D3,
         CRS_SEL_A0, CRS_SEL_A1, CRS_SEL_FB: begin
            w = st.bank[bk][lo]; // RL14
            if (pairable(sel)) begin
               up = st.bank[bk][pair_hi(sel)]; // RL2 RL3
            end
         end
         CRS_SEL_SB: w = st.sb;
         CRS_SEL_USP: w = st.user_stack_pointer;
         CRS_SEL_ISP: w = st.interrupt_stack_pointer;
         CRS_SEL_VTB: begin
            r = {12'h000, st.vtb};
            narrow = 1'b0;
         end
         CRS_SEL_PC: begin
            r = {12'h000, st.pc};
            narrow = 1'b0;
         end
         CRS_SEL_FLG: begin
            r = {21'h000000, st.flags_word}; // RL22
            narrow = 1'b0;
         end
         default: narrow = 1'b0;
      endcase
      if (narrow) begin
         case (sz)
            CRS_SZ_LOW: r = {24'h000000, w[7:0]};
            CRS_SZ_HIGH: r = {24'h000000, w[15:8]};
            CRS_SZ_PAIR: r = {up, w};
            default: r = {16'h0000, w};
         endcase
      end
      return r;
   endfunction : get

   // apb decode, zero wait states
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pwrite;
   assign apb_sel = crs_sel_t'(paddr[CRS_IDX_MSB:CRS_IDX_LSB]);
   assign apb_hit = (paddr[APB_AW-1:CRS_IDX_MSB+1] == '0) &&
                    (paddr[CRS_IDX_MSB:CRS_IDX_LSB] <= CRS_SEL_FLG);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !apb_hit;
   assign prdata = s_reg.prdata;

   // interrupt acceptance
   assign bank = s_reg.flags_word[CRS_F_B];
   assign cur_ipl = s_reg.flags_word[CRS_F_IPL_HI:CRS_F_IPL_LO]; // RL20
   assign irq_accept = irq_req &&
      (irq_nmi || (s_reg.flags_word[CRS_F_I] && (irq_level > cur_ipl))); // RL16 RL21

   // result zero test at operand width
   assign alu_zero = alu_wide ? (alu_result == 32'h00000000) :
                                (alu_result[15:0] == 16'h0000);

   // next state, later steps take precedence
   always_comb begin
      s_next = s_reg;
      if (apb_wr && apb_hit) begin
         s_next = put(s_next, bank, apb_sel, CRS_SZ_WORD, pwdata);
      end
      if (apb_setup && !pwrite) begin
         s_next.prdata = apb_hit ? get(s_reg, bank, apb_sel, CRS_SZ_WORD) : '0;
      end
      if (dp_wr_en) begin
         s_next = put(s_next, bank, dp_wr_sel, dp_wr_size, dp_wr_data);
      end
      s_next.rd_data = get(s_reg, bank, dp_rd_sel, dp_rd_size);
      if (pc_we) begin
         s_next.pc = pc_next; // RL6
      end
      if (alu_flag_we) begin
         s_next.flags_word[CRS_F_C] = alu_carry; // RL10
         s_next.flags_word[CRS_F_O] = alu_overflow; // RL15
         s_next.flags_word[CRS_F_Z] = alu_zero; // RL12
         s_next.flags_word[CRS_F_S] = alu_wide ? alu_result[31] : alu_result[15]; // RL13
      end
      if (swi_exec) begin
         s_next.flags_word[CRS_F_I] = 1'b0; // RL17
         if (swi_num < CRS_SWI_SYS_LIMIT) begin
            s_next.flags_word[CRS_F_U] = 1'b0; // RL19
         end
      end
      if (irq_accept) begin
         s_next.flags_word[CRS_F_I] = 1'b0; // RL17
         s_next.flags_word[CRS_F_U] = 1'b0; // RL19
         s_next.flags_word[CRS_F_IPL_HI:CRS_F_IPL_LO] = irq_level; // RL20
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= CRS_RST_STATE; // RL23
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs of the visible registers
   assign dp_rd_data = s_reg.rd_data;
   assign pc_value = s_reg.pc;
   assign vector_base = s_reg.vtb;
   assign stack_pointer = s_reg.flags_word[CRS_F_U] ? s_reg.user_stack_pointer : s_reg.interrupt_stack_pointer; // RL7 RL18
   assign frame_base_value = s_reg.bank[bank][3'(CRS_SEL_FB)];
   assign static_base_value = s_reg.sb;
   assign flags_value = s_reg.flags_word;

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   logic quiet;
   assign quiet = !apb_wr && !irq_accept && !swi_exec;

   property p_irq_clears_enable;
      irq_accept |=> !flags_value[CRS_F_I] && !flags_value[CRS_F_U];
   endproperty
   a_irq_clears_enable: assert property (p_irq_clears_enable) // RL17
      else $error("interrupt acknowledge left enable or stack flag set");

   property p_swi_sys_stack;
      swi_exec && (swi_num < CRS_SWI_SYS_LIMIT) |=> !flags_value[CRS_F_U];
   endproperty
   a_swi_sys_stack: assert property (p_swi_sys_stack) // RL19
      else $error("low software interrupt kept user stack");

   property p_swi_user_keeps_stack;
      swi_exec && (swi_num >= CRS_SWI_SYS_LIMIT) && !irq_accept && !apb_wr && !dp_wr_en
         |=> flags_value[CRS_F_U] == $past(flags_value[CRS_F_U]);
   endproperty
   a_swi_user_keeps_stack: assert property (p_swi_user_keeps_stack) // RL19
      else $error("high software interrupt changed stack flag");

   property p_priority_gate;
      irq_accept && !irq_nmi |-> (irq_level > cur_ipl) && flags_value[CRS_F_I];
   endproperty
   a_priority_gate: assert property (p_priority_gate) // RL21
      else $error("maskable interrupt accepted at or below current level");

   property p_enable_gate;
      irq_req && !irq_nmi && flags_value[CRS_F_I] && (irq_level > cur_ipl) |-> irq_accept;
   endproperty
   a_enable_gate: assert property (p_enable_gate) // RL16
      else $error("enabled higher priority interrupt not accepted");

   property p_alu_flags;
      alu_flag_we && quiet |=> flags_value[CRS_F_C] == $past(alu_carry) &&
         flags_value[CRS_F_O] == $past(alu_overflow); 
   endproperty
   a_alu_flags: assert property (p_alu_flags) // RL10
      else $error("carry or overflow flag not captured");

   property p_zero_flag;
      alu_flag_we && quiet |=> flags_value[CRS_F_Z] ==
         ($past(alu_wide) ? ($past(alu_result) == 32'h00000000) :
                            ($past(alu_result[15:0]) == 16'h0000));
   endproperty
   a_zero_flag: assert property (p_zero_flag) // RL12
      else $error("zero flag wrong after alu update");

   property p_sign_flag;
      alu_flag_we && alu_wide && quiet |=> flags_value[CRS_F_S] == $past(alu_result[31]);
   endproperty
   a_sign_flag: assert property (p_sign_flag) // RL13
      else $error("sign flag wrong after wide alu update");

   property p_pc_load;
      pc_we |=> pc_value == $past(pc_next);
   endproperty
   a_pc_load: assert property (p_pc_load) // RL6
      else $error("program counter did not take next address");

   property p_user_stack;
      dp_wr_en && dp_wr_sel == CRS_SEL_USP && dp_wr_size == CRS_SZ_WORD &&
         flags_value[CRS_F_U] && quiet |=> stack_pointer == $past(dp_wr_data[15:0]);
   endproperty
   a_user_stack: assert property (p_user_stack) // RL7
      else $error("user stack pointer not active with stack flag set");

   property p_pair_upper;
      dp_wr_en && dp_wr_sel == CRS_SEL_D0 && dp_wr_size == CRS_SZ_PAIR && !apb_wr
         |=> s_reg.bank[$past(bank)][3'(CRS_SEL_D2)] == $past(dp_wr_data[31:16]);
   endproperty
   a_pair_upper: assert property (p_pair_upper) // RL2
      else $error("pair write missed the upper data register");

   property p_byte_low;
      dp_wr_en && dp_wr_sel == CRS_SEL_D1 && dp_wr_size == CRS_SZ_LOW && !apb_wr
         |=> s_reg.bank[$past(bank)][3'(CRS_SEL_D1)][15:8] ==
             $past(s_reg.bank[bank][3'(CRS_SEL_D1)][15:8]);
   endproperty
   a_byte_low: assert property (p_byte_low) // RL1
      else $error("low byte write disturbed high byte");

   property p_bank_read;
      flags_value[CRS_F_B] && dp_rd_sel == CRS_SEL_D0 && dp_rd_size == CRS_SZ_WORD
         |=> dp_rd_data == {16'h0000, $past(s_reg.bank[1][0])};
   endproperty
   a_bank_read: assert property (p_bank_read) // RL14
      else $error("read did not come from bank one");

   // accepted request level becomes the new processor level
   property p_ipl_load;
      irq_accept |=> flags_value[CRS_F_IPL_HI:CRS_F_IPL_LO] == $past(irq_level);
   endproperty
   a_ipl_load: assert property (p_ipl_load) // RL20
      else $error("priority level not raised to accepted request level");

   property p_isp_active;
      dp_wr_en && dp_wr_sel == CRS_SEL_ISP && dp_wr_size == CRS_SZ_WORD &&
         !flags_value[CRS_F_U] && quiet |=> stack_pointer == $past(dp_wr_data[15:0]);
   endproperty
   a_isp_active: assert property (p_isp_active) // RL18
      else $error("interrupt stack pointer not active with stack flag clear");

   property p_sb_apb_write;
      apb_wr && apb_hit && apb_sel == CRS_SEL_SB && !dp_wr_en
         |=> static_base_value == $past(pwdata[CRS_DW-1:0]);
   endproperty
   a_sb_apb_write: assert property (p_sb_apb_write) // RL8
      else $error("bus write did not land in static base");

   c_irq: cover property (irq_accept && !irq_nmi);
   c_swi_user: cover property (swi_exec && (swi_num >= CRS_SWI_SYS_LIMIT));
   c_flag_read: cover property (apb_setup && !pwrite && apb_sel == CRS_SEL_FLG);
   c_pair: cover property (dp_wr_en && dp_wr_size == CRS_SZ_PAIR);
   c_nmi: cover property (irq_accept && irq_nmi);

endmodule : crs_cpu_register_set

// *** crs_pkg.sv ***
// package: cpu register set selectors, flag layout and state record
package crs_pkg;

   // widths of the register classes
   localparam int CRS_DW = 16;
   localparam int CRS_AW = 20;
   localparam int CRS_FW = 11;
   localparam int CRS_NREG = 7;

   // bus word index field of paddr
   localparam int CRS_IDX_LSB = 2;
   localparam int CRS_IDX_MSB = 5;

   // register selector, equal to the bus word index
   typedef enum logic [3:0] {
      CRS_SEL_D0 = 4'h0,
      CRS_SEL_D1 = 4'h1,
      CRS_SEL_D2 = 4'h2,
      CRS_SEL_D3 = 4'h3,
      CRS_SEL_A0 = 4'h4,
      CRS_SEL_A1 = 4'h5,
      CRS_SEL_FB = 4'h6,
      CRS_SEL_SB = 4'h7,
      CRS_SEL_VTB = 4'h8,
      CRS_SEL_PC = 4'h9,
      CRS_SEL_USP = 4'hA,
      CRS_SEL_ISP = 4'hB,
      CRS_SEL_FLG = 4'hC
   } crs_sel_t;

   // access size of a datapath transfer
   typedef enum logic [1:0] {
      CRS_SZ_LOW = 2'h0,
      CRS_SZ_HIGH = 2'h1,
      CRS_SZ_WORD = 2'h2,
      CRS_SZ_PAIR = 2'h3
   } crs_size_t;

   // flag word bit positions
   localparam int CRS_F_C = 0;
   localparam int CRS_F_D = 1;
   localparam int CRS_F_Z = 2;
   localparam int CRS_F_S = 3;
   localparam int CRS_F_B = 4;
   localparam int CRS_F_O = 5;
   localparam int CRS_F_I = 6;
   localparam int CRS_F_U = 7;
   localparam int CRS_F_IPL_LO = 8;
   localparam int CRS_F_IPL_HI = 10;

   // software interrupt numbers below this switch to the interrupt stack
   localparam logic [5:0] CRS_SWI_SYS_LIMIT = 6'h20;

   // complete state of the register set
   typedef struct packed {
      logic [1:0][CRS_NREG-1:0][CRS_DW-1:0] bank;
      logic [CRS_DW-1:0] sb;
      logic [CRS_DW-1:0] user_stack_pointer;
      logic [CRS_DW-1:0] interrupt_stack_pointer;
      logic [CRS_AW-1:0] vtb;
      logic [CRS_AW-1:0] pc;
      logic [CRS_FW-1:0] flags_word;
      logic [31:0] rd_data;
      logic [31:0] prdata;
   } crs_state_t;

   localparam crs_state_t CRS_RST_STATE = '0;

endpackage : crs_pkg

// *** test_cpu_register_set.sv ***
// file: self-checking bench for the cpu register set
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %h seen %h", n, e, g); end end

module test_cpu_register_set;
   import crs_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} crs_row_t;
   logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err, acc;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, dp_rd_data, dp_wr_data, alu_result, q;
   logic dp_wr_en, alu_flag_we, alu_wide, alu_carry, alu_overflow, pc_we;
   logic irq_req, irq_nmi, irq_accept, swi_exec;
   crs_sel_t dp_wr_sel, dp_rd_sel;
   crs_size_t dp_wr_size, dp_rd_size;
   logic [2:0] irq_level;
   logic [5:0] swi_num;
   logic [CRS_AW-1:0] pc_next, pc_value, vector_base;
   logic [CRS_DW-1:0] stack_pointer, frame_base_value, static_base_value;
   logic [CRS_FW-1:0] flags_value;
   int error_cnt, checked, cyc;
   // address, word written, word read back; flag word keeps debug and reserved bits 0
   crs_row_t rows [13] = '{
      '{8'h00, 32'hFFFF_1111, 32'h1111}, '{8'h04, 32'hFFFF_2222, 32'h2222},
      '{8'h08, 32'hFFFF_3333, 32'h3333}, '{8'h0C, 32'hFFFF_4444, 32'h4444},
      '{8'h10, 32'hFFFF_5555, 32'h5555}, '{8'h14, 32'hFFFF_6666, 32'h6666},
      '{8'h18, 32'hFFFF_7777, 32'h7777}, '{8'h1C, 32'hFFFF_8888, 32'h8888},
      '{8'h20, 32'hFFFA_BCDE, 32'hA_BCDE}, '{8'h24, 32'hFFF1_2345, 32'h1_2345},
      '{8'h28, 32'hFFFF_AAAA, 32'hAAAA}, '{8'h2C, 32'hFFFF_BBBB, 32'hBBBB},
      '{8'h30, 32'h0000_0735, 32'h735}};

   crs_core_model core (.*);
   crs_cpu_register_set dut (.*);

   // clock
   always #5 ref_clk = ~ref_clk;

   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         results();
      end
   end

   // one apb transfer; read data and error taken at the ready edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // wait for ready; pready is tied high, so this wait ends at the first edge
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task results;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   // main sequence
   initial begin
      {ref_clk, nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      error_cnt = 0;
      checked = 0;
      cyc = 0;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, '0);
         `CHK("reset", 32'h0, q)
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, '0);
         `CHK("readback", rows[i].e, q)
         `CHK("slverr", 1'b0, err)
      end
      @(negedge ref_clk);
      `CHK("vtb", 20'hABCDE, vector_base)
      `CHK("pc", 20'h12345, pc_value)
      `CHK("sb", 16'h8888, static_base_value)
      `CHK("sp isp", 16'hBBBB, stack_pointer)
      `CHK("fb bank1", 16'h0, frame_base_value)
      apb(1'b1, 8'h18, 32'h9999);
      apb(1'b1, 8'h30, 32'h725);
      @(negedge ref_clk);
      `CHK("fb bank0", 16'h7777, frame_base_value)
      apb(1'b0, 8'h34, '0);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h0, q)
      apb(1'b1, 8'h40, 32'h1);
      apb(1'b0, 8'h00, '0);
      `CHK("bank0 kept", 32'h1111, q)
      core.dp_write(CRS_SEL_D0, CRS_SZ_PAIR, 32'h1234_5678);
      apb(1'b0, 8'h08, '0);
      `CHK("pair upper", 32'h1234, q)
      core.dp_read(CRS_SEL_D0, CRS_SZ_PAIR, q);
      `CHK("pair read", 32'h1234_5678, q)
      core.dp_write(CRS_SEL_D1, CRS_SZ_HIGH, 32'hAB);
      core.dp_write(CRS_SEL_D1, CRS_SZ_LOW, 32'hCD);
      apb(1'b0, 8'h04, '0);
      `CHK("byte halves", 32'hABCD, q)
      core.dp_write(CRS_SEL_A0, CRS_SZ_PAIR, 32'hCAFE_F00D);
      apb(1'b0, 8'h14, '0);
      `CHK("addr upper", 32'hCAFE, q)
      core.dp_read(CRS_SEL_A0, CRS_SZ_PAIR, q);
      `CHK("addr pair", 32'hCAFE_F00D, q)
      core.alu(1'b0, 32'h0001_0000, 1'b1, 1'b0);
      @(negedge ref_clk);
      `CHK("zero carry", 11'h705, flags_value)
      core.alu(1'b1, 32'h8000_0000, 1'b0, 1'b1);
      @(negedge ref_clk);
      `CHK("sign ovf", 11'h728, flags_value)
      apb(1'b1, 8'h30, 32'h3C0);
      @(negedge ref_clk);
      `CHK("sp usp", 16'hAAAA, stack_pointer)
      core.dp_write(CRS_SEL_USP, CRS_SZ_WORD, 32'h0000_1357);
      @(negedge ref_clk);
      `CHK("usp dp", 16'h1357, stack_pointer)
      core.irq(1'b0, 3'd3, acc);
      `CHK("equal level", 1'b0, acc)
      core.irq(1'b0, 3'd4, acc);
      `CHK("higher level", 1'b1, acc)
      @(negedge ref_clk);
      `CHK("ack flags", 11'h400, flags_value)
      `CHK("ack sp", 16'hBBBB, stack_pointer)
      core.dp_write(CRS_SEL_ISP, CRS_SZ_WORD, 32'h0000_2468);
      @(negedge ref_clk);
      `CHK("isp dp", 16'h2468, stack_pointer)
      core.irq(1'b0, 3'd7, acc);
      `CHK("masked", 1'b0, acc)
      core.irq(1'b1, 3'd6, acc);
      `CHK("nmi", 1'b1, acc)
      apb(1'b1, 8'h30, 32'h0C0);
      core.swi(6'd32);
      @(negedge ref_clk);
      `CHK("swi 32", 11'h080, flags_value)
      core.swi(6'd31);
      @(negedge ref_clk);
      `CHK("swi 31", 11'h000, flags_value)
      core.pc_load(20'hFEDCB);
      @(negedge ref_clk);
      `CHK("pc load", 20'hFEDCB, pc_value)
      // mid-run reset, driven at a rising edge
      @(posedge ref_clk);
      nrst <= 1'b0;
      @(negedge ref_clk);
      `CHK("rst pc", 20'h0, pc_value)
      `CHK("rst flags", 11'h0, flags_value)
      `CHK("rst sp", 16'h0, stack_pointer)
      `CHK("rst vtb", 20'h0, vector_base)
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      apb(1'b0, 8'h2C, '0);
      `CHK("rst isp", 32'h0, q)
      results();
   end
endmodule : test_cpu_register_set
